// ==== logic/dmi_top.sv ====
// Data memory interface: internal RAM decode, expanded RAM, external bus,
// dual data pointer. Assumes a CPU core drives one request at a time.
`timescale 1ns/1ps
// How it works
// - Lower RAM 00h-7Fh, direct and indirect
// - Lowest 32 bytes: four banks, eight registers
// - Bank bits pick 00h, 08h, 10h, 18h
// - Bit area 20h-2Fh, bits 00h-7Fh
// - Upper RAM 80h-FFh indirect only
// - 1024 byte expanded RAM via external moves
// - Select bit steers expanded RAM, on-chip default
// - Select 0 on-chip, 1 external bus
// - Size field limits expanded RAM, full default
// - Low address muxed with data, high separate
// - Latch strobe marks valid low address
// - Active low read and write strobes
// - External cycle lasts six CPU clocks, 18 stretched
// - Strobe width 3, stretched 15
// - Register indirect moves on the external bus output port two contents
// - Two pointers share addresses 83h, 84h
// - Select bit picks active data pointer
// - Select bit set picks second pointer
// - Bit 2 reads zero, increment toggles
// - Increment toggles the pointer select bit
module dmi_top (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Special function register port
  input  wire logic                  i_sfr_wr,
  input  wire logic                  i_sfr_rd,
  input  wire logic [7:0]            i_sfr_addr,
  input  wire logic [7:0]            i_sfr_wdata,
  input  wire logic [7:0]            i_program_status_word,
  input  wire logic [7:0]            i_port_two_sfr,
  output logic      [7:0]            o_sfr_rdata_ff,
  output logic                       o_sfr_hit_ff,
  // Internal RAM port
  input  wire dmi_pkg::dmi_iram_req_t i_iram_req,
  output logic      [7:0]            o_iram_rdata_ff,
  output logic                       o_iram_bit_ff,
  output logic                       o_iram_ack_ff,
  output logic                       o_iram_err_ff,
  output logic                       o_busy_ff,
  // External move port
  input  wire dmi_pkg::dmi_xmov_req_t i_xmov_req,
  input  wire logic                  i_data_pointer_inc,
  output logic      [7:0]            o_xmov_rdata_ff,
  output logic                       o_xmov_done_ff,
  // Multiplexed bus pins
  input  wire logic [7:0]            i_addr_data_low_lines,
  output dmi_pkg::dmi_xbus_t         o_xbus_ff
);
  import dmi_pkg::*;

  dmi_state_t state_ff, nxt_state;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic [15:0] dptr0_ff, dptr1_ff, nxt_dptr0, nxt_dptr1;
  logic        ext_sel_ff, stretch_ff, x_we_ff, ri_ff;
  logic [1:0]  size_ff;
  logic        gf3_ff, psel_ff;
  logic [15:0] xa_ff;
  logic [7:0]  xd_ff, bit_byte_ff;
  logic [2:0]  bit_sel_ff;
  logic        bit_we_ff, bit_val_ff;
  logic [7:0]  sync1_ff, sync2_ff, sync3_ff, filt_ff;
  logic [7:0]  iram_rdata, expanded_ram_rdata;
  logic        iram_we, expanded_ram_we;
  logic [7:0]  iram_wd;
  dmi_xbus_t   nxt_xbus;
  logic        nxt_ack, nxt_err, nxt_done, nxt_bit;
  logic [7:0]  nxt_xrdata, nxt_sfr_rdata;

  // Decode of internal addresses
  wire logic [1:0]  bank      = i_program_status_word[4:3];
  wire logic [7:0]  reg_addr  = {3'h0, bank, i_iram_req.addr[2:0]};
  wire logic [7:0]  bit_byte  = BIT_AREA_BASE + {4'h0, i_iram_req.addr[6:3]};
  wire logic        is_bit    = i_iram_req.mode == MODE_BIT;
  wire logic        is_reg    = i_iram_req.mode == MODE_REGISTER;
  wire logic        bad_dir   = i_iram_req.mode == MODE_DIRECT && i_iram_req.addr[7];
  wire logic        bad_bit   = is_bit && i_iram_req.addr[7];
  wire logic [7:0]  dec_addr  = is_reg ? reg_addr : (is_bit ? bit_byte : i_iram_req.addr);
  wire logic [7:0]  iram_addr = (state_ff == ST_BIT) ? bit_byte_ff : dec_addr;
  wire logic        iram_go   = state_ff == ST_IDLE && i_iram_req.valid;
  wire logic        xmov_go   = state_ff == ST_IDLE && i_xmov_req.valid && !i_iram_req.valid;

  // Decode of external move addresses
  wire logic [15:0] data_pointer_sel  = psel_ff ? dptr1_ff : dptr0_ff;
  wire logic [15:0] xaddr     = i_xmov_req.via_ri ? {i_port_two_sfr, i_xmov_req.ri_addr}
                                                  : data_pointer_sel;
  wire logic        in_size   = i_xmov_req.via_ri ||
                                (xaddr[15:10] == 6'h00 && xaddr[9:8] <= size_ff);
  wire logic        onchip    = !ext_sel_ff && in_size;
  wire logic [9:0]  expanded_ram_addr = i_xmov_req.via_ri ? {2'h0, i_xmov_req.ri_addr} : xaddr[9:0];
  wire logic [7:0]  auxc1_rd  = {4'h0, gf3_ff, 1'b0, 1'b0, psel_ff};
  wire logic [4:0]  strobe_w  = stretch_ff ? STROBE_W_STRETCH : STROBE_W_STD;
  wire logic [4:0]  last_ph   = ADDR_PHASES + strobe_w;
  wire logic        sfr_wr_dph  = i_sfr_wr && i_sfr_addr == DPH_ADDR;
  wire logic        sfr_wr_dpl  = i_sfr_wr && i_sfr_addr == DPL_ADDR;
  wire logic        sfr_wr_aux  = i_sfr_wr && i_sfr_addr == AUXC_ADDR;
  wire logic        sfr_wr_aux1 = i_sfr_wr && i_sfr_addr == AUXC1_ADDR;
  wire logic        sfr_known = i_sfr_addr == DPH_ADDR || i_sfr_addr == DPL_ADDR ||
                                i_sfr_addr == AUXC_ADDR || i_sfr_addr == AUXC1_ADDR;
  // Pin value that counts: taken under the strobe, settled once stages agree
  wire logic [7:0]  pin_now   = (sync2_ff == sync3_ff) ? sync3_ff : filt_ff;

  // Bus pin levels for one phase of an external cycle
  function automatic dmi_xbus_t bus_phase(input logic [4:0] p, input logic [4:0] w,
                                          input logic we, input logic [15:0] a,
                                          input logic [7:0] d);
    dmi_xbus_t b;
    logic      strobe;
    b         = XBUS_IDLE;
    strobe    = p >= ADDR_PHASES && p < ADDR_PHASES + w;
    b.ale     = p == 5'h00;
    b.addr_high = a[15:8];
    b.adl_out = (p < ADDR_PHASES) ? a[7:0] : d;
    b.adl_oe_n = !(p < ADDR_PHASES || we);
    b.rd_n    = !(strobe && !we);
    b.wr_n    = !(strobe && we);
    return b;
  endfunction

  dmi_ram #(.AW(IRAM_AW)) u_iram (
    .i_clk      (i_clk),
    .i_we       (iram_we),
    .i_addr     (iram_addr),
    .i_wdata    (iram_wd),
    .o_rdata_ff (iram_rdata)
  );

  dmi_ram #(.AW(EXPANDED_RAM_AW)) u_expanded_ram (
    .i_clk      (i_clk),
    .i_we       (expanded_ram_we),
    .i_addr     (expanded_ram_addr),
    .i_wdata    (i_xmov_req.wdata),
    .o_rdata_ff (expanded_ram_rdata)
  );

  assign o_iram_rdata_ff = iram_rdata;

  // Access sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_xbus   = XBUS_IDLE;
    nxt_ack    = 1'b0;
    nxt_err    = 1'b0;
    nxt_done   = 1'b0;
    nxt_bit    = o_iram_bit_ff;
    nxt_xrdata = o_xmov_rdata_ff;
    iram_we    = 1'b0;
    iram_wd    = i_iram_req.wdata;
    expanded_ram_we    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (iram_go) begin
          if (bad_dir || bad_bit) begin
            nxt_ack = 1'b1;
            nxt_err = 1'b1;
          end else if (is_bit) begin
            nxt_state = ST_BIT;
          end else begin
            iram_we = i_iram_req.we;
            nxt_ack = 1'b1;
          end
        end else if (xmov_go && onchip) begin
          expanded_ram_we = i_xmov_req.we;
          nxt_state = ST_XRD;
        end else if (xmov_go) begin
          nxt_cnt   = 5'h00;
          nxt_state = ST_XBUS;
          nxt_xbus  = bus_phase(5'h00, strobe_w, i_xmov_req.we, xaddr, i_xmov_req.wdata);
        end
      end
      ST_BIT: begin
        nxt_bit = iram_rdata[bit_sel_ff];
        iram_wd = iram_rdata;
        iram_wd[bit_sel_ff] = bit_val_ff;
        iram_we = bit_we_ff;
        nxt_ack = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_XRD: begin
        nxt_xrdata = expanded_ram_rdata;
        nxt_done   = 1'b1;
        nxt_state  = ST_IDLE;
      end
      ST_XBUS: begin
        if (cnt_ff == last_ph) begin
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt  = cnt_ff + 5'h01;
          nxt_xbus = bus_phase(nxt_cnt, strobe_w, x_we_ff, xa_ff, xd_ff);
        end
        if (!x_we_ff && cnt_ff == last_ph) begin
          nxt_xrdata = pin_now;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Data pointers, write wins over increment
  always_comb begin
    nxt_dptr0 = dptr0_ff;
    nxt_dptr1 = dptr1_ff;
    if (i_data_pointer_inc && psel_ff) begin
      nxt_dptr1 = dptr1_ff + 16'h0001;
    end else if (i_data_pointer_inc) begin
      nxt_dptr0 = dptr0_ff + 16'h0001;
    end
    if (sfr_wr_dph && psel_ff) begin
      nxt_dptr1[15:8] = i_sfr_wdata;
    end else if (sfr_wr_dph) begin
      nxt_dptr0[15:8] = i_sfr_wdata;
    end
    if (sfr_wr_dpl && psel_ff) begin
      nxt_dptr1[7:0] = i_sfr_wdata;
    end else if (sfr_wr_dpl) begin
      nxt_dptr0[7:0] = i_sfr_wdata;
    end
  end

  // Register read mux
  always_comb begin
    case (i_sfr_addr)
      DPH_ADDR:   nxt_sfr_rdata = data_pointer_sel[15:8];
      DPL_ADDR:   nxt_sfr_rdata = data_pointer_sel[7:0];
      AUXC_ADDR:  nxt_sfr_rdata = {2'h0, stretch_ff, 1'b0, size_ff, ext_sel_ff, 1'b0};
      AUXC1_ADDR: nxt_sfr_rdata = auxc1_rd;
      default:    nxt_sfr_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 5'h00;
      o_xbus_ff <= XBUS_IDLE;
      o_iram_ack_ff <= 1'b0;
      o_iram_err_ff <= 1'b0;
      o_iram_bit_ff <= 1'b0;
      o_xmov_done_ff <= 1'b0;
      o_xmov_rdata_ff <= 8'h00;
      o_busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      o_xbus_ff <= nxt_xbus;
      o_iram_ack_ff <= nxt_ack;
      o_iram_err_ff <= nxt_err;
      o_iram_bit_ff <= nxt_bit;
      o_xmov_done_ff <= nxt_done;
      o_xmov_rdata_ff <= nxt_xrdata;
      o_busy_ff <= nxt_state != ST_IDLE;
    end
  end

  // Request capture for multi-cycle accesses
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      xa_ff <= 16'h0000;
      xd_ff <= 8'h00;
      x_we_ff <= 1'b0;
      ri_ff <= 1'b0;
      bit_byte_ff <= 8'h00;
      bit_sel_ff <= 3'h0;
      bit_we_ff <= 1'b0;
      bit_val_ff <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      xa_ff <= xaddr;
      xd_ff <= i_xmov_req.wdata;
      x_we_ff <= i_xmov_req.we;
      ri_ff <= i_xmov_req.via_ri;
      bit_byte_ff <= bit_byte;
      bit_sel_ff <= i_iram_req.addr[2:0];
      bit_we_ff <= i_iram_req.we;
      bit_val_ff <= i_iram_req.wdata[0];
    end
  end

  // Control registers and pointers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dptr0_ff <= 16'h0000;
      dptr1_ff <= 16'h0000;
      ext_sel_ff <= 1'b0;
      size_ff <= SIZE_RESET;
      stretch_ff <= 1'b0;
      gf3_ff <= AUXC1_RESET[AUXC1_GF3_BIT];
      psel_ff <= AUXC1_RESET[AUXC1_SEL_BIT];
      o_sfr_rdata_ff <= 8'h00;
      o_sfr_hit_ff <= 1'b0;
    end else begin
      dptr0_ff <= nxt_dptr0;
      dptr1_ff <= nxt_dptr1;
      if (sfr_wr_aux && state_ff != ST_XBUS) begin
        ext_sel_ff <= i_sfr_wdata[AUXC_EXT_BIT];
        size_ff <= i_sfr_wdata[AUXC_SIZE_LSB +: 2];
        stretch_ff <= i_sfr_wdata[AUXC_STRETCH_BIT];
      end
      if (sfr_wr_aux1) begin
        gf3_ff <= i_sfr_wdata[AUXC1_GF3_BIT];
        psel_ff <= i_sfr_wdata[AUXC1_SEL_BIT];
      end
      o_sfr_rdata_ff <= nxt_sfr_rdata;
      o_sfr_hit_ff <= i_sfr_rd && sfr_known;
    end
  end

  // Three stage pin synchroniser, change accepted when stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      sync3_ff <= 8'h00;
      filt_ff <= 8'h00;
    end else begin
      sync1_ff <= i_addr_data_low_lines;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        filt_ff <= sync3_ff;
      end
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_bank_map: assert property (iram_go && is_reg |-> iram_addr[7:5] == 3'h0 &&
    iram_addr[4:3] == i_program_status_word[4:3]) else $error("bank decode wrong");
  a_bit_area: assert property (iram_go && is_bit && !bad_bit |->
    iram_addr == 8'h20 + {4'h0, i_iram_req.addr[6:3]} ##1 state_ff == ST_BIT)
    else $error("bit area decode wrong");
  a_direct_upper: assert property (iram_go && bad_dir |-> !iram_we ##1
    o_iram_ack_ff && o_iram_err_ff) else $error("direct upper access not refused");
  a_onchip_sel: assert property (xmov_go && !ext_sel_ff && i_xmov_req.via_ri |->
    (!o_xbus_ff.ale)[*3]) else $error("on-chip move reached bus");
  a_cycle_len: assert property ($rose(o_xbus_ff.ale) && !stretch_ff |->
    ##6 o_xmov_done_ff) else $error("external cycle not six clocks");
  a_strobe_std: assert property ($fell(o_xbus_ff.rd_n) && !stretch_ff |->
    (!o_xbus_ff.rd_n)[*3] ##1 o_xbus_ff.rd_n) else $error("read strobe not 3 wide");
  a_strobe_long: assert property ($fell(o_xbus_ff.wr_n) && stretch_ff |->
    ##14 !o_xbus_ff.wr_n ##1 o_xbus_ff.wr_n) else $error("write strobe not 15 wide");
  a_latch_addr: assert property ($rose(o_xbus_ff.ale) |-> !o_xbus_ff.adl_oe_n
    ##1 !o_xbus_ff.ale && !o_xbus_ff.adl_oe_n) else $error("address not held at latch");
  a_rd_release: assert property (!o_xbus_ff.rd_n |-> o_xbus_ff.adl_oe_n)
    else $error("low lines driven during read");
  a_ri_high: assert property ($rose(o_xbus_ff.ale) && ri_ff |->
    o_xbus_ff.addr_high == i_port_two_sfr) else $error("port two contents not shown");
  a_bit2_zero: assert property ($past(i_sfr_rd) && $past(i_sfr_addr) == AUXC1_ADDR |->
    o_sfr_rdata_ff[2] == 1'b0) else $error("always-zero bit read high");
  a_sel_toggle: assert property (sfr_wr_aux1 && i_sfr_wdata == auxc1_rd + 8'h01 |=>
    psel_ff != $past(psel_ff)) else $error("increment did not toggle select");

  c_ext_read: cover property ($rose(o_xbus_ff.ale) ##1 !o_xbus_ff.rd_n);
  c_ext_write_long: cover property ($fell(o_xbus_ff.wr_n) && stretch_ff);
  c_bit_write: cover property (state_ff == ST_BIT && bit_we_ff);
  c_onchip_move: cover property (state_ff == ST_XRD);

endmodule

// ==== shared/dmi_pkg.sv ====
// Constants and types for the data memory interface block.
// Assumes one 20 MHz CPU clock; used by every file of the block except the RAM.
package dmi_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Special function register addresses
  localparam logic [7:0] DPH_ADDR   = 8'h83;
  localparam logic [7:0] DPL_ADDR   = 8'h84;
  localparam logic [7:0] AUXC_ADDR  = 8'h8e;
  localparam logic [7:0] AUXC1_ADDR = 8'ha2;

  // Auxiliary control fields and reset value
  localparam int unsigned AUXC_EXT_BIT     = 1;
  localparam int unsigned AUXC_SIZE_LSB    = 2;
  localparam int unsigned AUXC_STRETCH_BIT = 5;
  localparam logic [1:0]  SIZE_RESET       = 2'h3;

  // Auxiliary control one fields and reset value
  localparam int unsigned AUXC1_SEL_BIT  = 0;
  localparam int unsigned AUXC1_ZERO_BIT = 2;
  localparam int unsigned AUXC1_GF3_BIT  = 3;
  localparam logic [7:0]  AUXC1_RESET    = 8'h00;

  // Internal memory map
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam int unsigned IRAM_AW      = 8;
  localparam int unsigned EXPANDED_RAM_AW      = 10;

  // External cycle timing in CPU clock periods
  localparam logic [4:0] ADDR_PHASES     = 5'h02;
  localparam logic [4:0] STROBE_W_STD    = 5'h03;
  localparam logic [4:0] STROBE_W_STRETCH = 5'h0f;

  // Internal access modes
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_REGISTER,
    MODE_BIT
  } dmi_mode_t;

  typedef enum {
    ST_IDLE,
    ST_BIT,
    ST_XRD,
    ST_XBUS
  } dmi_state_t;

  typedef struct packed {
    logic            valid;
    logic            we;
    dmi_mode_t       mode;
    logic [7:0]      addr;
    logic [7:0]      wdata;
  } dmi_iram_req_t;

  typedef struct packed {
    logic       valid;
    logic       we;
    logic       via_ri;
    logic [7:0] ri_addr;
    logic [7:0] wdata;
  } dmi_xmov_req_t;

  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       adl_oe_n;
    logic [7:0] adl_out;
    logic [7:0] addr_high;
  } dmi_xbus_t;

  localparam dmi_xbus_t XBUS_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00};

endpackage

// ==== logic/dmi_ram.sv ====
// Single port synchronous RAM with registered read data.
// Assumes the user holds address and write enable for one clock.
`timescale 1ns/1ps
module dmi_ram #(
  parameter int unsigned AW = 8
) (
  // Clock
  input  wire logic          i_clk,
  // Access
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata_ff
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Contents stay undefined until written
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata_ff <= mem[i_addr];
  end

endmodule

// ==== tb/dmi_xmem_model.sv ====
// External data memory on the multiplexed bus.
// Assumes the bench resolves the low lines from the device enable and this model.
`timescale 1ns/1ps
module dmi_xmem_model (
  // Clock
  input  wire logic               i_clk,
  // Bus
  input  wire dmi_pkg::dmi_xbus_t i_xbus,
  input  wire logic [7:0]         i_lines,
  output logic      [7:0]         o_data
);
  import dmi_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q;
  logic [7:0]  last_q;

  initial begin
    addr_q = 16'h0000;
    last_q = 8'h00;
    for (int k = 0; k < 65536; k++) begin
      mem[k] = 8'h00;
    end
  end

  // Latch the low address when the strobe falls
  always @(negedge i_xbus.ale) begin
    addr_q = {i_xbus.addr_high, i_lines};
  end

  // Write data while the write strobe is low
  always @(posedge i_clk) begin
    last_q <= i_lines;
    if (i_xbus.wr_n == 1'b0) begin
      mem[addr_q] <= i_lines;
    end
  end

  // Drive only under the read strobe, otherwise a changing pattern
  assign o_data = (i_xbus.rd_n == 1'b0) ? mem[addr_q] : ~last_q;
endmodule

// ==== tb/data_memory_interface_bench.sv ====
// Self-checking bench for the data memory interface top.
// Assumes a 20 MHz clock and the external memory model on the bus.
`timescale 1ns/1ps
module data_memory_interface_bench;
  import dmi_pkg::*;
  logic          clk;
  logic          rst_n;
  logic          s_wr;
  logic          s_rd;
  logic [7:0]    s_addr;
  logic [7:0]    s_wd;
  logic [7:0]    program_status_word;
  logic [7:0]    p2;
  dmi_iram_req_t ireq;
  dmi_xmov_req_t xreq;
  logic          inc;
  logic [7:0]    s_rdata;
  logic          s_hit;
  logic [7:0]    i_rdata;
  logic          i_bit;
  logic          i_ack;
  logic          i_err;
  logic [7:0]    x_rdata;
  logic          x_done;
  dmi_xbus_t     xbus;
  logic [7:0]    m_data;
  logic [7:0]    r_data;
  logic          r_err;
  logic          r_bit;
  logic          busy;
  logic          r_busy;
  logic [7:0]    b;
  wire  [7:0]    lines = xbus.adl_oe_n ? m_data : xbus.adl_out;
  int            err_total = 0;
  int            n_compared = 0;
  int            t_ale;
  int            t_done;
  int            rdl;
  int            wrl;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  dmi_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_sfr_wr(s_wr), .i_sfr_rd(s_rd),
    .i_sfr_addr(s_addr), .i_sfr_wdata(s_wd), .i_program_status_word(program_status_word),
    .i_port_two_sfr(p2), .o_sfr_rdata_ff(s_rdata), .o_sfr_hit_ff(s_hit),
    .i_iram_req(ireq), .o_iram_rdata_ff(i_rdata), .o_iram_bit_ff(i_bit),
    .o_iram_ack_ff(i_ack), .o_iram_err_ff(i_err), .o_busy_ff(busy), .i_xmov_req(xreq),
    .i_data_pointer_inc(inc), .o_xmov_rdata_ff(x_rdata), .o_xmov_done_ff(x_done),
    .i_addr_data_low_lines(lines), .o_xbus_ff(xbus));

  dmi_xmem_model model_u (.i_clk(clk), .i_xbus(xbus), .i_lines(lines), .o_data(m_data));

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic conclude;
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tmo;
    err_total++;
    $display("[ERR] handshake expected 1 seen 0");
    conclude;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    s_wr = 1'b1;
    s_addr = a;
    s_wd = d;
    tick;
    s_wr = 1'b0;
    tick;
  endtask

  task automatic srchk(input string nm, input logic [7:0] a, input logic [7:0] e,
                       input logic h);
    s_rd = 1'b1;
    s_addr = a;
    tick;
    s_rd = 1'b0;
    chk(nm, {7'h00, h, e}, {7'h00, s_hit, s_rdata});
    tick;
  endtask

  task automatic ir(input logic we, input dmi_mode_t m, input logic [7:0] a,
                    input logic [7:0] d);
    int i;
    ireq = '{1'b1, we, m, a, d};
    tick;
    ireq.valid = 1'b0;
    r_busy = busy;
    for (i = 0; i < 8 && i_ack !== 1'b1; i++) begin
      tick;
    end
    if (i_ack !== 1'b1) tmo;
    r_data = i_rdata;
    r_err = i_err;
    r_bit = i_bit;
    tick;
  endtask

  task automatic xm(input logic we, input logic via, input logic [7:0] ri,
                    input logic [7:0] d);
    int i;
    xreq = '{1'b1, we, via, ri, d};
    t_ale = -1;
    rdl = 0;
    wrl = 0;
    tick;
    xreq.valid = 1'b0;
    for (i = 0; i < 40; i++) begin
      if (xbus.ale === 1'b1 && t_ale < 0) t_ale = i;
      if (xbus.rd_n === 1'b0) rdl++;
      if (xbus.wr_n === 1'b0) wrl++;
      if (x_done === 1'b1) break;
      tick;
    end
    if (x_done !== 1'b1) tmo;
    t_done = i - t_ale;
    r_data = x_rdata;
    tick;
  endtask

  initial begin
    rst_n = 1'b0;
    s_wr = 1'b0;
    s_rd = 1'b0;
    s_addr = 8'h00;
    s_wd = 8'h00;
    program_status_word = 8'h00;
    p2 = 8'hab;
    ireq = '0;
    xreq = '0;
    inc = 1'b0;
    repeat (3) tick;
    rst_n = 1'b1;
    srchk("auxc1_reset", AUXC1_ADDR, 8'h00, 1'b1);
    srchk("auxc_reset", AUXC_ADDR, 8'h0c, 1'b1);
    srchk("unmapped", 8'h90, 8'h00, 1'b0);
    for (b = 8'h00; b < 8'h04; b++) begin
      program_status_word = {3'h0, b[1:0], 3'h0};
      ir(1'b1, MODE_REGISTER, 8'h05, 8'h30 + b);
    end
    for (b = 8'h00; b < 8'h04; b++) begin
      ir(1'b0, MODE_DIRECT, b * 8'h08 + 8'h05, 8'h00);
      chk("bank", 8'h30 + b, r_data);
    end
    ir(1'b1, MODE_DIRECT, 8'h7f, 8'h77);
    ir(1'b0, MODE_INDIRECT, 8'h7f, 8'h00);
    chk("lower", 8'h77, r_data);
    chk("busy_byte", 1'b0, r_busy);
    ir(1'b1, MODE_INDIRECT, 8'h80, 8'h5a);
    ir(1'b1, MODE_DIRECT, 8'h80, 8'ha5);
    chk("direct_upper_err", 1'b1, r_err);
    ir(1'b0, MODE_INDIRECT, 8'h80, 8'h00);
    chk("upper", 8'h5a, r_data);
    ir(1'b1, MODE_DIRECT, 8'h21, 8'h00);
    ir(1'b1, MODE_BIT, 8'h0f, 8'h01);
    chk("busy_bit", 1'b1, r_busy);
    ir(1'b0, MODE_DIRECT, 8'h21, 8'h00);
    chk("bit_area", 8'h80, r_data);
    ir(1'b0, MODE_BIT, 8'h0f, 8'h00);
    chk("bit_read", 1'b1, r_bit);
    ir(1'b1, MODE_BIT, 8'h80, 8'h01);
    chk("bit_err", 1'b1, r_err);
    sw(DPH_ADDR, 8'h03);
    sw(DPL_ADDR, 8'hff);
    sw(AUXC1_ADDR, 8'h05);
    srchk("auxc1_zero", AUXC1_ADDR, 8'h01, 1'b1);
    sw(DPH_ADDR, 8'h12);
    sw(DPL_ADDR, 8'h33);
    inc = 1'b1;
    tick;
    inc = 1'b0;
    srchk("dpl_inc", DPL_ADDR, 8'h34, 1'b1);
    sw(AUXC1_ADDR, 8'h02);
    srchk("auxc1_toggle", AUXC1_ADDR, 8'h00, 1'b1);
    srchk("dph_first", DPH_ADDR, 8'h03, 1'b1);
    xm(1'b1, 1'b0, 8'h00, 8'hc3);
    chk("expanded_ram_time", 16'd2, t_done);
    xm(1'b0, 1'b0, 8'h00, 8'h00);
    chk("expanded_ram_read", 8'hc3, r_data);
    xm(1'b1, 1'b1, 8'h10, 8'h4e);
    xm(1'b0, 1'b1, 8'h10, 8'h00);
    chk("ri_onchip", 8'h4e, r_data);
    chk("ri_no_bus", 8'h00, model_u.mem[16'hab10]);
    sw(AUXC_ADDR, 8'h00);
    xm(1'b1, 1'b0, 8'h00, 8'h99);
    chk("size_bus", 8'h99, model_u.mem[16'h03ff]);
    sw(AUXC_ADDR, 8'h0e);
    model_u.mem[16'h1234] = 8'h6b;
    sw(AUXC1_ADDR, 8'h01);
    xm(1'b0, 1'b0, 8'h00, 8'h00);
    chk("ext_read", 8'h6b, r_data);
    chk("ext_addr", 16'h1234, model_u.addr_q);
    chk("ext_cycle", 16'd6, t_done);
    chk("rd_width", 16'd3, rdl);
    xm(1'b1, 1'b1, 8'h56, 8'h3c);
    chk("ri_write", 8'h3c, model_u.mem[16'hab56]);
    chk("wr_width", 16'd3, wrl);
    sw(AUXC_ADDR, 8'h2e);
    srchk("auxc_stretch", AUXC_ADDR, 8'h2e, 1'b1);
    xm(1'b0, 1'b0, 8'h00, 8'h00);
    chk("rd_stretch", 16'd15, rdl);
    chk("stretch_cycle", 16'd18, t_done);
    chk("rd_stretch_data", 8'h6b, r_data);
    xm(1'b1, 1'b1, 8'h57, 8'h3d);
    chk("wr_stretch", 16'd15, wrl);
    chk("ri_stretch", 8'h3d, model_u.mem[16'hab57]);
    conclude;
  end
endmodule
